// *** rtl/pll_control_register_logic.sv ***
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
module pll_control_register_logic
	import loop_ctl_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire logic                         hsel,
	input  wire logic [11:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic      [31:0]                  hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	input  wire loop_ctl_pkg::clock_status_t  status,
	input  wire logic                         vco_near_target,
	output loop_ctl_pkg::loop_drive_t         drive,
	output logic                              monitor_reset_request,
	output logic                              limp_entry_request,
	output logic                              irq
);
	import loop_ctl_pkg::*;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic        wr_pending;
	logic        rd_status_pending;
	logic [11:0] wr_addr;
	logic [7:0]  loop_control;
	logic        limp_write_used;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	fail_state_t fail_state;
	fail_state_t next_fail_state;

	// Only whole-word writes are decoded; narrower writes are answered but ignored.
	wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	wire word_size  = (hsize == 3'h2);
	wire take_write = addr_phase && hwrite && word_size;
	wire take_read  = addr_phase && !hwrite;

	// Registered write address; data arrives one cycle later.
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_pending        <= 1'b0;
			wr_addr           <= 12'h000;
			rd_status_pending <= 1'b0;
		end else begin
			wr_pending        <= take_write;
			wr_addr           <= haddr;
			rd_status_pending <= take_read && haddr == ADDR_IRQ_STATUS;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------------------------------
	// Control register write qualification
	// ----------------------------------------------------------------
	wire       wr_ctl = wr_pending && wr_addr == ADDR_LOOP_CONTROL;
	wire [7:0] wd     = hwdata[7:0] & LOOP_CONTROL_WMASK;
	wire       limp   = status.limp_clock_active;

	wire next_monitor = (wr_ctl && !limp) ? wd[BIT_MONITOR] : loop_control[BIT_MONITOR];
	wire next_power = (wr_ctl && !status.loop_clock_select) ?
		wd[BIT_POWER] : loop_control[BIT_POWER];
	// Wait-stop holds the automatic bit high, so writes are moot meanwhile.
	wire next_auto = status.loop_wait_stop ? 1'b1 :
		(wr_ctl ? wd[BIT_AUTO] : loop_control[BIT_AUTO]);
	wire next_acq  = wr_ctl ? wd[BIT_ACQ] : loop_control[BIT_ACQ];
	wire next_tick = wr_ctl ? wd[BIT_TICK_RUN] : loop_control[BIT_TICK_RUN];
	wire next_wdog = wr_ctl ? wd[BIT_WDOG_RUN] : loop_control[BIT_WDOG_RUN];
	// Write-once outside special modes; never cleared while limp mode runs.
	wire limp_wr_ok = wr_ctl && (status.special_mode || !limp_write_used);
	wire limp_clear_blocked = limp && !wd[BIT_LIMP_EN];
	wire next_limp_en = (limp_wr_ok && !limp_clear_blocked) ?
		wd[BIT_LIMP_EN] : loop_control[BIT_LIMP_EN];

	// The control register itself.
	always_ff @(posedge clk) begin
		if (reset) begin
			loop_control    <= LOOP_CONTROL_RESET;
			limp_write_used <= 1'b0;
		end else begin
			loop_control    <= {next_monitor, next_power, next_auto, next_acq,
				1'b0, next_tick, next_wdog, next_limp_en};
			limp_write_used <= limp_write_used | wr_ctl;
		end
	end

	// ----------------------------------------------------------------
	// Drives to the loop and dividers
	// ----------------------------------------------------------------
	wire full_stop   = status.stop_mode && !status.pseudo_stop_select;
	wire pseudo_stop = status.stop_mode && status.pseudo_stop_select;
	wire monitor_on  = loop_control[BIT_MONITOR] && !full_stop;

	assign drive.monitor_active = monitor_on;
	assign drive.loop_powered   = loop_control[BIT_POWER] | limp;
	assign drive.auto_bandwidth = loop_control[BIT_AUTO];
	// Automatic mode picks acquisition while the oscillator is far from target.
	assign drive.high_bandwidth = loop_control[BIT_AUTO] ?
		!vco_near_target : loop_control[BIT_ACQ];
	// Dividers freeze, not reinitialise, in pseudo stop when their run bit is clear.
	assign drive.tick_run     = !pseudo_stop || loop_control[BIT_TICK_RUN];
	assign drive.watchdog_run = !pseudo_stop || loop_control[BIT_WDOG_RUN];
	assign drive.clear_loop_select = limp || status.stop_mode ||
		(status.wait_mode && status.loop_wait_stop);

	// ----------------------------------------------------------------
	// Crystal failure response
	// ----------------------------------------------------------------
	// One action per failure episode; it rearms when the failure clears.
	wire fail_seen = monitor_on && status.clock_failure;
	assign next_fail_state = (fail_state == FAIL_IDLE && fail_seen) ? FAIL_ACTED :
		(fail_state == FAIL_ACTED && !fail_seen) ? FAIL_IDLE : fail_state;
	wire fail_event = (fail_state == FAIL_IDLE) && fail_seen;
	wire ev_reset   = fail_event && !loop_control[BIT_LIMP_EN];
	wire ev_limp    = fail_event && loop_control[BIT_LIMP_EN];

	always_ff @(posedge clk) begin
		if (reset) begin
			fail_state            <= FAIL_IDLE;
			monitor_reset_request <= 1'b0;
			limp_entry_request    <= 1'b0;
		end else begin
			case (fail_state)
				FAIL_IDLE, FAIL_ACTED: fail_state <= next_fail_state;
				default:               fail_state <= FAIL_IDLE;
			endcase
			monitor_reset_request <= ev_reset;
			limp_entry_request    <= ev_limp;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	// A new event wins over the clear caused by reading the status word.
	wire [1:0] events = {ev_limp, ev_reset};
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_status <= 2'h0;
			irq_mask   <= IRQ_MASK_RESET;
		end else begin
			irq_status <= (rd_status_pending ? 2'h0 : irq_status) | events;
			if (wr_pending && wr_addr == ADDR_IRQ_MASK)
				irq_mask <= hwdata[1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Read data is registered at the address phase so it stands in the data phase.
	wire [31:0] rd_mux =
		(haddr == ADDR_LOOP_CONTROL) ? {24'h000000, loop_control} :
		(haddr == ADDR_IRQ_STATUS)   ? {30'h00000000, irq_status} :
		(haddr == ADDR_IRQ_MASK)     ? {30'h00000000, irq_mask} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (reset)
			hrdata <= 32'h00000000;
		else if (take_read)
			hrdata <= rd_mux;
	end

endmodule

// *** rtl/loop_ctl_pkg.sv ***
package loop_ctl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_LOOP_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h004;
	localparam logic [11:0] ADDR_IRQ_MASK     = 12'h008;
	localparam logic [7:0]  LOOP_CONTROL_RESET = 8'hf1;
	localparam logic [7:0]  LOOP_CONTROL_WMASK = 8'hf7;
	localparam logic [1:0]  IRQ_MASK_RESET     = 2'h0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_MONITOR   = 7;
	localparam int BIT_POWER     = 6;
	localparam int BIT_AUTO      = 5;
	localparam int BIT_ACQ       = 4;
	localparam int BIT_TICK_RUN  = 2;
	localparam int BIT_WDOG_RUN  = 1;
	localparam int BIT_LIMP_EN   = 0;
	localparam int IRQ_BIT_RESET = 0;
	localparam int IRQ_BIT_LIMP  = 1;

	// AHB-Lite encodings.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	// Status inputs from the surrounding clock generator.
	typedef struct packed {
		logic limp_clock_active;
		logic loop_clock_select;
		logic loop_wait_stop;
		logic pseudo_stop_select;
		logic stop_mode;
		logic wait_mode;
		logic special_mode;
		logic clock_failure;
	} clock_status_t;

	// Controls driven out to the loop and dividers.
	typedef struct packed {
		logic monitor_active;
		logic loop_powered;
		logic auto_bandwidth;
		logic high_bandwidth;
		logic tick_run;
		logic watchdog_run;
		logic clear_loop_select;
	} loop_drive_t;

	typedef enum logic [1:0] {
		FAIL_IDLE  = 2'b01,
		FAIL_ACTED = 2'b10
	} fail_state_t;

endpackage

// *** dv/pll_ctl_props.sv ***
// --------------------
// Port checks
// --------------------
module pll_ctl_props
	import loop_ctl_pkg::*;
(
	input wire logic                        clk,
	input wire logic                        reset,
	input wire loop_ctl_pkg::clock_status_t status,
	input wire logic                        vco_near_target,
	input wire loop_ctl_pkg::loop_drive_t   drive,
	input wire logic                        monitor_reset_request,
	input wire logic                        limp_entry_request,
	input wire logic                        irq
);
	// Everything runs on the bus clock and rests while reset is high.
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_full_stop; drive.monitor_active |-> !(status.stop_mode && !status.pseudo_stop_select); endproperty
	a_full_stop: assert property (p_full_stop) else $error("monitor live in full stop");
	property p_limp_power; status.limp_clock_active |-> drive.loop_powered; endproperty
	a_limp_power: assert property (p_limp_power) else $error("loop off in limp mode");
	property p_clear_sel; status.limp_clock_active || status.stop_mode || (status.wait_mode && status.loop_wait_stop) |-> drive.clear_loop_select; endproperty
	a_clear_sel: assert property (p_clear_sel) else $error("clock select not cleared");
	property p_auto_filter; drive.auto_bandwidth |-> drive.high_bandwidth == !vco_near_target; endproperty
	a_auto_filter: assert property (p_auto_filter) else $error("automatic filter wrong");
	property p_wait_auto; status.loop_wait_stop ##1 status.loop_wait_stop |-> drive.auto_bandwidth; endproperty
	a_wait_auto: assert property (p_wait_auto) else $error("wait-stop did not hold auto");
	property p_fail_act; $rose(status.clock_failure && drive.monitor_active) |=> monitor_reset_request != limp_entry_request; endproperty
	a_fail_act: assert property (p_fail_act) else $error("no single failure response");
	property p_fail_cause; monitor_reset_request || limp_entry_request |-> $past(status.clock_failure && drive.monitor_active); endproperty
	a_fail_cause: assert property (p_fail_cause) else $error("response without detection");
	property p_irq_reset; $past(reset) |-> !irq; endproperty
	a_irq_reset: assert property (p_irq_reset) else $error("irq high after reset");
endmodule

// *** dv/tb.sv ***
// --------------------
// Loop control bench
// --------------------
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import loop_ctl_pkg::*;
	logic          clk = 1'b0;
	logic          reset = 1'b1;
	logic          hsel = 1'b0;
	logic [11:0]   haddr = 12'h000;
	logic [1:0]    htrans = 2'h0;
	logic          hwrite = 1'b0;
	logic [31:0]   hwdata = 32'h0;
	logic          vco_near_target = 1'b0;
	clock_status_t st = '0;
	logic [31:0]   hrdata, rdat;
	logic          hreadyout, hresp, mrr, ler, irq;
	loop_drive_t   drive;
	int            n_mismatch = 0;
	int            check_count = 0;
	// Free-running bus clock at 125 MHz.
	always #4 clk = ~clk;
	pll_control_register_logic pll_control_register_logic_i (.clk(clk), .reset(reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .status(st), .vco_near_target(vco_near_target), .drive(drive),
		.monitor_reset_request(mrr), .limp_entry_request(ler), .irq(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One single transfer; the trailing delay lets combinational outputs settle before checks.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, HTRANS_NONSEQ, w, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdat = hrdata;
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic fail();
		@(posedge clk) st.clock_failure <= 1'b1;
		@(posedge clk) st.clock_failure <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic t_reset();
		rd(ADDR_LOOP_CONTROL, 32'hf1);
		rd(ADDR_IRQ_STATUS, 32'h0);
		rd(ADDR_IRQ_MASK, 32'h0);
		rd(12'h00c, 32'h0);
		chk(32'(hresp), 32'h0);
		chk(32'(drive.high_bandwidth), 32'h1);
		@(posedge clk) vco_near_target <= 1'b1;
		@(posedge clk) #1 chk(32'(drive.high_bandwidth), 32'h0);
		$display("reset test done");
	endtask
	task automatic t_write_once();
		bus(1'b1, ADDR_LOOP_CONTROL, 32'h0e);
		rd(ADDR_LOOP_CONTROL, 32'h06);
		chk(32'(drive.high_bandwidth), 32'h0);
		chk(32'(drive.loop_powered), 32'h0);
		bus(1'b1, ADDR_LOOP_CONTROL, 32'hf7);
		rd(ADDR_LOOP_CONTROL, 32'hf6);
		$display("write once test done");
	endtask
	task automatic t_special_locks();
		@(posedge clk) st.special_mode <= 1'b1;
		bus(1'b1, ADDR_LOOP_CONTROL, 32'h11);
		rd(ADDR_LOOP_CONTROL, 32'h11);
		chk(32'(drive.high_bandwidth), 32'h1);
		@(posedge clk) st.loop_clock_select <= 1'b1;
		bus(1'b1, ADDR_LOOP_CONTROL, 32'h40);
		rd(ADDR_LOOP_CONTROL, 32'h00);
		@(posedge clk) {st.loop_clock_select, st.loop_wait_stop} <= 2'b01;
		bus(1'b1, ADDR_LOOP_CONTROL, 32'h00);
		rd(ADDR_LOOP_CONTROL, 32'h20);
		@(posedge clk) st.loop_wait_stop <= 1'b0;
		$display("special and lock test done");
	endtask
	// Limp mode must pin the monitor and keep the limp enable from being cleared, whatever software writes.
	task automatic t_limp();
		bus(1'b1, ADDR_LOOP_CONTROL, 32'h81);
		@(posedge clk) st.limp_clock_active <= 1'b1;
		bus(1'b1, ADDR_LOOP_CONTROL, 32'h00);
		rd(ADDR_LOOP_CONTROL, 32'h81);
		chk(32'(drive.loop_powered), 32'h1);
		chk(32'(drive.clear_loop_select), 32'h1);
		@(posedge clk) st.limp_clock_active <= 1'b0;
		$display("limp test done");
	endtask
	task automatic t_failure();
		bus(1'b1, ADDR_IRQ_MASK, 32'h3);
		fail();
		chk(32'(irq), 32'h1);
		rd(ADDR_IRQ_STATUS, 32'h2);
		chk(32'(irq), 32'h0);
		bus(1'b1, ADDR_LOOP_CONTROL, 32'h80);
		bus(1'b1, ADDR_IRQ_MASK, 32'h0);
		fail();
		chk(32'(irq), 32'h0);
		rd(ADDR_IRQ_STATUS, 32'h1);
		@(posedge clk) st.stop_mode <= 1'b1;
		fail();
		rd(ADDR_IRQ_STATUS, 32'h0);
		chk(32'(drive.monitor_active), 32'h0);
		chk(32'(drive.clear_loop_select), 32'h1);
		@(posedge clk) st.pseudo_stop_select <= 1'b1;
		fail();
		rd(ADDR_IRQ_STATUS, 32'h1);
		chk(32'(drive.tick_run), 32'h0);
		chk(32'(drive.watchdog_run), 32'h0);
		bus(1'b1, ADDR_LOOP_CONTROL, 32'h86);
		chk(32'(drive.tick_run), 32'h1);
		chk(32'(drive.watchdog_run), 32'h1);
		$display("failure test done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence after a 20-cycle reset.
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_write_once();
		t_special_locks();
		t_limp();
		t_failure();
		stop_test();
	end
	// Watchdog: the tests need about 120 cycles, so this margin only trips on a hang.
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		stop_test();
	end
endmodule
bind pll_control_register_logic pll_ctl_props pll_ctl_props_i (.clk(clk), .reset(reset),
	.status(status), .vco_near_target(vco_near_target), .drive(drive), .irq(irq),
	.monitor_reset_request(monitor_reset_request), .limp_entry_request(limp_entry_request));
